// *** hw/exec_pkg.sv ***
// Constants, decode functions and carriers of the clear and call executor
// Operation
// RL1 - Clear-file writes 00h to the addressed file register and sets zero flag.
// RL2 - Clear-file pattern 00 0001 1fff ffff, seven-bit address, one cycle.
// RL3 - Pattern 00 0001 0xxx xxxx clears accumulator and sets zero flag.
// RL4 - Call first pushes current program counter plus one onto stack top.
// RL5 - Call 10 0kkk kkkk kkkk loads eleven-bit operand into counter bits 10:0.
// RL6 - Call loads counter bits 12:11 from page latch bits 4:3.
// RL7 - Call takes two cycles, flags unchanged, fetched next instruction discarded.
// RL8 - Pattern 00 0000 0110 0100 clears watchdog counter to 00h in one cycle.
// RL9 - Watchdog clear also resets watchdog prescaler count to zero.
// RL10 - Watchdog clear sets timeout_flag_n and power_down_flag_n to one; here a power-down request in the same cycle still clears pd_n_reg.
package exec_pkg;
    localparam int             PC_W         = 13;
    localparam int             K_W          = 11;
    localparam int             SP_W         = 3;
    localparam int             STACK_DEPTH  = 8;
    localparam logic [13:0]    OP_HI_MASK   = 14'h3f80;
    localparam logic [13:0]    CLR_FILE_VAL = 14'h0180;
    localparam logic [13:0]    CLR_ACC_VAL  = 14'h0100;
    localparam logic [13:0]    CALL_MASK    = 14'h3800;
    localparam logic [13:0]    CALL_VAL     = 14'h2000;
    localparam logic [13:0]    WDT_CLR_OP   = 14'h0064;
    localparam logic [7:0]     ZERO_BYTE    = 8'h00;
    localparam logic [7:0]     BYTE_MAX     = 8'hff;
    localparam logic [7:0]     BYTE_ONE     = 8'h01;
    localparam logic [12:0]    PC_ONE       = 13'h0001;
    localparam logic [12:0]    PC_RESET     = 13'h0000;
    localparam logic [2:0]     SP_ONE       = 3'h1;
    localparam int             PAGE_HI      = 4;
    localparam int             PAGE_LO      = 3;
    localparam int             ST_Z         = 2;
    localparam int             ST_PD        = 3;
    localparam int             ST_TO        = 4;
    localparam logic [2:0]     REG_STATUS   = 3'h0;
    localparam logic [2:0]     REG_PAGE     = 3'h1;
    localparam logic [2:0]     REG_ACC      = 3'h2;
    localparam logic [2:0]     REG_PC_LO    = 3'h3;
    localparam logic [2:0]     REG_PC_HI    = 3'h4;
    localparam logic [2:0]     REG_WDT      = 3'h5;
    localparam logic [2:0]     REG_PRESC    = 3'h6;

    // File register write port
    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } file_wr_t;

    // Opcode decoders
    function automatic logic is_clear_file(input logic [13:0] i);
        return (i & OP_HI_MASK) == CLR_FILE_VAL;
    endfunction
    function automatic logic is_clear_acc(input logic [13:0] i);
        return (i & OP_HI_MASK) == CLR_ACC_VAL;
    endfunction
    function automatic logic is_call(input logic [13:0] i);
        return (i & CALL_MASK) == CALL_VAL;
    endfunction
    function automatic logic is_wdt_clear(input logic [13:0] i);
        return i == WDT_CLR_OP;
    endfunction
endpackage

// *** hw/clear_call_exec.sv ***
// Executor for clear-file, clear-accumulator, call and watchdog clear
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module clear_call_exec (
    input  wire logic              mclk,           // 20 MHz clock
    input  wire logic              rst_n,          // Async reset
    input  wire logic [13:0]       instr,          // Fetched instruction
    input  wire logic              instr_valid,    // One pulse per cycle
    input  wire logic              power_down_req, // Sleep entry pulse
    input  wire logic [2:0]        reg_addr,       // Register address
    input  wire logic [7:0]        reg_wdata,      // Register write data
    input  wire logic              reg_wr,         // Write strobe
    input  wire logic              reg_rd,         // Read strobe
    output logic [7:0]             reg_rdata,      // Read data, next cycle
    output exec_pkg::file_wr_t     file_wr,        // File write port
    output logic [12:0]            pc,             // Program counter
    output logic [12:0]            return_stack_top, // Last pushed address, zero while the stack pointer is zero
    output logic                   exec_busy,      // Second call cycle
    output logic                   wdt_timeout     // Watchdog overflow
);

    ////////////////////////////////////////////////////////////////////
    // State
    logic [12:0]        pc_reg;
    logic [12:0]        pc_next;
    logic [2:0]         sp_reg;
    logic [2:0]         sp_next;
    logic [12:0]        stack_mem [exec_pkg::STACK_DEPTH];
    logic               push_en;
    logic [12:0]        pc_plus_one;
    logic               flush_reg;
    logic               flush_next;
    logic [7:0]         acc_reg;
    logic [7:0]         acc_next;
    logic               z_reg;
    logic               z_next;
    logic               to_n_reg;
    logic               to_n_next;
    logic               pd_n_reg;
    logic               pd_n_next;
    logic [7:0]         page_reg;
    logic [7:0]         page_next;
    exec_pkg::file_wr_t file_wr_reg;
    exec_pkg::file_wr_t file_wr_next;
    logic [7:0]         presc_reg;
    logic [7:0]         presc_next;
    logic [7:0]         wdt_reg;
    logic [7:0]         wdt_next;
    logic               timeout;
    logic [7:0]         rdata_reg;
    logic [7:0]         rdata_next;
    logic               exec;
    logic               do_call;
    logic               do_clr_file;
    logic               do_clr_acc;
    logic               do_wdt_clr;
    logic [12:0]        call_target;

    ////////////////////////////////////////////////////////////////////
    // Decode of the executing instruction
    assign exec        = instr_valid && !flush_reg;
    assign do_call     = exec && exec_pkg::is_call(instr);
    assign do_clr_file = exec && exec_pkg::is_clear_file(instr);
    assign do_clr_acc  = exec && exec_pkg::is_clear_acc(instr);
    assign do_wdt_clr  = exec && exec_pkg::is_wdt_clear(instr);
    assign pc_plus_one = pc_reg + exec_pkg::PC_ONE;
    assign call_target = {page_reg[exec_pkg::PAGE_HI:exec_pkg::PAGE_LO],
                          instr[exec_pkg::K_W-1:0]};

    ////////////////////////////////////////////////////////////////////
    // Core next state
    always_comb begin
        pc_next      = pc_reg;
        sp_next      = sp_reg;
        push_en      = 1'b0;
        flush_next   = flush_reg;
        acc_next     = acc_reg;
        z_next       = z_reg;
        to_n_next    = to_n_reg;
        pd_n_next    = pd_n_reg;
        page_next    = page_reg;
        file_wr_next = '0;
        if (instr_valid) begin
            if (flush_reg) begin
                flush_next = 1'b0;              // Discarded fetch [RL7]
            end else if (do_call) begin
                push_en    = 1'b1;              // Push return address [RL4]
                sp_next    = sp_reg + exec_pkg::SP_ONE;
                pc_next    = call_target;       // Paged target [RL5] [RL6]
                flush_next = 1'b1;              // Two cycles [RL7]
            end else begin
                pc_next = pc_plus_one;          // Single cycle [RL2]
            end
        end
        // Clear a file register
        if (do_clr_file) begin
            file_wr_next.we   = 1'b1;           // [RL2]
            file_wr_next.addr = instr[6:0];
            file_wr_next.data = exec_pkg::ZERO_BYTE; // [RL1]
            z_next            = 1'b1;           // [RL1]
        end
        // Clear the accumulator
        if (do_clr_acc) begin
            acc_next = exec_pkg::ZERO_BYTE;     // [RL3]
            z_next   = 1'b1;                    // [RL3]
        end
        // Status flags, a power-down request wins; a watchdog clear suppresses the overflow
        if (do_wdt_clr) begin
            to_n_next = 1'b1;                   // [RL10]
            pd_n_next = 1'b1;                   // [RL10]
        end
        if (power_down_req) begin
            pd_n_next = 1'b0;
        end
        if (timeout) begin
            to_n_next = 1'b0;
        end
        // Software page latch write
        if (reg_wr && reg_addr == exec_pkg::REG_PAGE) begin
            page_next = reg_wdata;
        end
    end

    // Core registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg      <= exec_pkg::PC_RESET;
            sp_reg      <= '0;
            flush_reg   <= 1'b0;
            acc_reg     <= exec_pkg::ZERO_BYTE;
            z_reg       <= 1'b0;
            to_n_reg    <= 1'b1;
            pd_n_reg    <= 1'b1;
            page_reg    <= exec_pkg::ZERO_BYTE;
            file_wr_reg <= '0;
        end else begin
            pc_reg      <= pc_next;
            sp_reg      <= sp_next;
            flush_reg   <= flush_next;
            acc_reg     <= acc_next;
            z_reg       <= z_next;
            to_n_reg    <= to_n_next;
            pd_n_reg    <= pd_n_next;
            page_reg    <= page_next;
            file_wr_reg <= file_wr_next;
        end
    end

    // Return stack storage, circular with eight entries
    always_ff @(posedge mclk) begin
        if (push_en) begin
            stack_mem[sp_reg] <= pc_plus_one;   // [RL4]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Watchdog counter and prescaler
    assign timeout = (wdt_reg == exec_pkg::BYTE_MAX) &&
                     (presc_reg == exec_pkg::BYTE_MAX) && !do_wdt_clr;

    always_comb begin
        presc_next = presc_reg + exec_pkg::BYTE_ONE;
        wdt_next   = wdt_reg;
        if (presc_reg == exec_pkg::BYTE_MAX) begin
            wdt_next = wdt_reg + exec_pkg::BYTE_ONE;
        end
        if (do_wdt_clr) begin
            wdt_next   = exec_pkg::ZERO_BYTE;   // [RL8]
            presc_next = exec_pkg::ZERO_BYTE;   // [RL9]
        end
    end

    // Watchdog registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= exec_pkg::ZERO_BYTE;
            wdt_reg   <= exec_pkg::ZERO_BYTE;
        end else begin
            presc_reg <= presc_next;
            wdt_reg   <= wdt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read port
    always_comb begin
        rdata_next = exec_pkg::ZERO_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                exec_pkg::REG_STATUS: begin
                    rdata_next[exec_pkg::ST_Z]  = z_reg;
                    rdata_next[exec_pkg::ST_PD] = pd_n_reg;
                    rdata_next[exec_pkg::ST_TO] = to_n_reg;
                end
                exec_pkg::REG_PAGE:  rdata_next = page_reg;
                exec_pkg::REG_ACC:   rdata_next = acc_reg;
                exec_pkg::REG_PC_LO: rdata_next = pc_reg[7:0];
                exec_pkg::REG_PC_HI: rdata_next = {3'h0, pc_reg[12:8]};
                exec_pkg::REG_WDT:   rdata_next = wdt_reg;
                exec_pkg::REG_PRESC: rdata_next = presc_reg;
                default:             rdata_next = exec_pkg::ZERO_BYTE;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= exec_pkg::ZERO_BYTE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_rdata        = rdata_reg;
    assign file_wr          = file_wr_reg;
    assign pc               = pc_reg;
    assign return_stack_top = (sp_reg == '0) ? exec_pkg::PC_RESET :
                              stack_mem[sp_reg - exec_pkg::SP_ONE];
    assign exec_busy        = flush_reg;
    assign wdt_timeout      = timeout;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    clr_file_write_a: assert property ( // [RL1]
        do_clr_file |=> file_wr.we && file_wr.data == 8'h00 &&
                        file_wr.addr == $past(instr[6:0]) && z_reg)
        else $error("clear-file write wrong");

    clr_file_cycle_a: assert property ( // [RL2]
        do_clr_file |=> !exec_busy && pc == $past(pc_plus_one))
        else $error("clear-file not single cycle");

    clr_acc_zero_a: assert property ( // [RL3]
        do_clr_acc |=> acc_reg == 8'h00 && z_reg && !file_wr.we)
        else $error("accumulator clear wrong");

    call_push_a: assert property ( // [RL4]
        do_call |=> return_stack_top == $past(pc_plus_one))
        else $error("return address not pushed");

    call_target_a: assert property ( // [RL5]
        do_call |=> pc[10:0] == $past(instr[10:0]) &&
                    pc[12:11] == $past(page_reg[4:3]))
        else $error("call target wrong");

    call_two_cycle_a: assert property ( // [RL7]
        do_call ##1 instr_valid |=> !exec_busy && $stable(pc) && $stable(z_reg)
                                    && !file_wr.we)
        else $error("call second cycle wrong");

    // Prescaler restarts from zero unless a further clear follows at once
    wdt_clear_a: assert property ( // [RL8] [RL9]
        do_wdt_clr |=> (wdt_reg == exec_pkg::ZERO_BYTE &&
                        presc_reg == exec_pkg::ZERO_BYTE)
                       ##1 (presc_reg == exec_pkg::BYTE_ONE || $past(do_wdt_clr)))
        else $error("watchdog not cleared");

    call_page_a: assert property ( // [RL6]
        do_call |=> pc[exec_pkg::PC_W-1:exec_pkg::K_W] ==
                    $past(page_reg[exec_pkg::PAGE_HI:exec_pkg::PAGE_LO]))
        else $error("call page bits wrong");

    // Overflow clears the flag; a watchdog clear in the overflow cycle suppresses the overflow
    timeout_flag_a: assert property (
        wdt_timeout |=> !to_n_reg)
        else $error("timeout did not clear flag");

    wdt_flags_a: assert property ( // [RL10]
        do_wdt_clr && !power_down_req |=> to_n_reg && pd_n_reg)
        else $error("timeout or power-down flag not set");

endmodule // clear_call_exec

// *** test/tb_top.sv ***
// Directed testbench for the clear and call executor
`timescale 1ns/1ns
module tb_top;
    logic              mclk;
    logic              rst_n;
    logic [13:0]       instr;
    logic              instr_valid;
    logic              power_down_req;
    logic [2:0]        reg_addr;
    logic [7:0]        reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [7:0]        reg_rdata;
    exec_pkg::file_wr_t file_wr;
    logic [12:0]       pc;
    logic [12:0]       return_stack_top;
    logic              exec_busy;
    logic              wdt_timeout;
    int                fail_count;
    int                checks;
    int                cycles;
    int                wait_n;

    ////////////////////////////////////////////////////////////////////////////
    // Design under test
    clear_call_exec clear_call_exec_inst (
        .mclk             (mclk),
        .rst_n            (rst_n),
        .instr            (instr),
        .instr_valid      (instr_valid),
        .power_down_req   (power_down_req),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .file_wr          (file_wr),
        .pc               (pc),
        .return_stack_top (return_stack_top),
        .exec_busy        (exec_busy),
        .wdt_timeout      (wdt_timeout)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 20 MHz and hang guard
    initial mclk = 1'b0;
    always #25 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 70000) begin
            fail_count++;
            $display("mismatch at %0t: run did not finish", $time);
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic do_reset();
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
    endtask

    // One instruction, effects settled on return
    task automatic exec_op(input logic [13:0] op);
        @(posedge mclk);
        instr       <= op;
        instr_valid <= 1'b1;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
    endtask

    // Two instructions on consecutive cycles, effects settled on return
    task automatic exec_pair(input logic [13:0] op_a, input logic [13:0] op_b);
        @(posedge mclk);
        instr       <= op_a;
        instr_valid <= 1'b1;
        @(posedge mclk);
        instr       <= op_b;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic reg_write(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    // Read data is sampled in the single cycle it stands
    task automatic read_check(input logic [2:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
        check({8'h00, d}, {8'h00, exp}, what);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        fail_count     = 0;
        checks         = 0;
        cycles         = 0;
        rst_n          = 1'b0;
        instr          = 14'h0000;
        instr_valid    = 1'b0;
        power_down_req = 1'b0;
        reg_addr       = 3'h0;
        reg_wdata      = 8'h00;
        reg_wr         = 1'b0;
        reg_rd         = 1'b0;
        do_reset();

        // Clear-file from a clear zero flag
        read_check(exec_pkg::REG_STATUS, 8'h18, "status after reset");
        exec_op(14'h0185);
        check({file_wr.we, file_wr.addr, file_wr.data}, 16'h8500, "clear file write");
        check({3'h0, pc}, 16'h0001, "pc after clear file");
        read_check(exec_pkg::REG_STATUS, 8'h1c, "zero flag by clear file");
        $display("test clear_file done");

        // Clear-accumulator after a second reset
        do_reset();
        exec_op(14'h017f);
        check({15'h0000, file_wr.we}, 16'h0000, "no file write on clear acc");
        read_check(exec_pkg::REG_STATUS, 8'h1c, "zero flag by clear acc");
        read_check(exec_pkg::REG_ACC, 8'h00, "accumulator cleared");
        $display("test clear_accumulator done");

        // Register port: page latch, read-only place, unmapped place
        reg_write(exec_pkg::REG_PAGE, 8'h08);
        read_check(exec_pkg::REG_PAGE, 8'h08, "page latch readback");
        reg_write(exec_pkg::REG_ACC, 8'h55);
        read_check(exec_pkg::REG_ACC, 8'h00, "accumulator write ignored");
        read_check(3'h7, 8'h00, "unmapped read");
        $display("test registers done");

        // Call with page bits 01, then discarded fetch
        exec_op(14'h2123);
        check({3'h0, pc}, 16'h0923, "call target");
        check({3'h0, return_stack_top}, 16'h0002, "pushed return");
        check({15'h0000, exec_busy}, 16'h0001, "busy after call");
        exec_op(14'h01aa);
        check({15'h0000, file_wr.we}, 16'h0000, "discarded fetch wrote");
        check({3'h0, pc}, 16'h0923, "pc held on discard");
        check({15'h0000, exec_busy}, 16'h0000, "busy dropped");
        read_check(exec_pkg::REG_STATUS, 8'h1c, "flags kept by call");

        // Call with page bits 10 and full operand, back to back with its fetch
        reg_write(exec_pkg::REG_PAGE, 8'h10);
        exec_pair(14'h27ff, 14'h01aa);
        check({3'h0, pc}, 16'h17ff, "call upper page held");
        check({3'h0, return_stack_top}, 16'h0924, "second pushed return");
        check({15'h0000, file_wr.we}, 16'h0000, "back to back discard wrote");
        check({15'h0000, exec_busy}, 16'h0000, "busy dropped back to back");
        exec_op(14'h0000);
        check({3'h0, pc}, 16'h1800, "pc steps after discard");
        $display("test call done");

        // Watchdog clear after sleep entry
        @(posedge mclk);
        power_down_req <= 1'b1;
        @(posedge mclk);
        power_down_req <= 1'b0;
        read_check(exec_pkg::REG_STATUS, 8'h14, "power down flag low");
        exec_op(14'h0064);
        read_check(exec_pkg::REG_PRESC, 8'h01, "prescaler restarted");
        read_check(exec_pkg::REG_WDT, 8'h00, "watchdog cleared");
        read_check(exec_pkg::REG_STATUS, 8'h1c, "timeout and power flags set");
        $display("test watchdog_clear done");

        // Full watchdog count after a clear, then the flag set again
        exec_op(exec_pkg::WDT_CLR_OP);
        wait_n = 0;
        while (wdt_timeout !== 1'b1) begin
            @(posedge mclk);
            #1;
            wait_n++;
        end
        check(wait_n[15:0], 16'hffff, "cycles from clear to timeout");
        read_check(exec_pkg::REG_STATUS, 8'h0c, "timeout flag low");
        exec_op(exec_pkg::WDT_CLR_OP);
        read_check(exec_pkg::REG_STATUS, 8'h1c, "timeout flag set again");
        $display("test watchdog_timeout done");
        results();
    end
endmodule // tb_top
